// ### verilog/dcfp_defs.svh
`ifndef DCFP_DEFS_SVH
`define DCFP_DEFS_SVH

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define DCFP_DATA_W 9
`define DCFP_ADDR_W 16
// Almost-empty and almost-full offsets default to seven words
`define DCFP_OFS_LO_RST 9'h007
`define DCFP_OFS_HI_RST 9'h000
`define DCFP_DATA_RST 9'h000

`endif

// ### verilog/dcfp_pkg.sv
package dcfp_pkg;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // Function of the dual-purpose enable, caught during reset
  typedef enum logic {
    DCFP_MODE_LOAD = 1'b0,
    DCFP_MODE_DUAL = 1'b1
  } dcfp_mode_t;

  // Offset register selector, stepped by each offset access
  typedef enum logic [1:0] {
    DCFP_SEL_E_LO = 2'b00,
    DCFP_SEL_E_HI = 2'b01,
    DCFP_SEL_F_LO = 2'b10,
    DCFP_SEL_F_HI = 2'b11
  } dcfp_sel_t;

  // The four nine-bit offset registers travel together
  typedef struct packed {
    logic [8:0] f_hi;
    logic [8:0] f_lo;
    logic [8:0] e_hi;
    logic [8:0] e_lo;
  } dcfp_ofs_t;

endpackage

// ### verilog/dcfp_fifo.sv
// Contract
// - Dual-enable mode: write when primary low, secondary high, not full.
// - Load mode: primary enable qualifies buffer writes only while load is high and not full.
// - Secondary pin function is caught during reset: high dual, low load.
// - Writes while full are ignored; contents stay untouched.
// - A read needs both read enables low; reader drives both.
// - Each read edge with enables low and not empty shows next word.
// - While load is active, write edges fill offset registers instead.
// - Load low in load mode: read edges show offset register contents.
// - Empty flag low when no words; updated only on read clock.
// - Full flag low when full; updated only on write clock.
// - Almost-empty low at or below empty offset; read clock domain.
// - Almost-full low within full offset of capacity; write clock domain.
// - Reset returns to empty; one reset needed before first access.
// - Output drive enable low drives data; high floats it.
// - Nine-bit data carried unchanged from input to output.
// - First-in first-out order, depth 64K or 128K words.
// - Clocks may be tied or independent; reads and writes concurrent.
// - Held write enables store one word per write clock until full.
// - Unprogrammed offsets default to empty plus 7 and full minus 7.
// - Offset writes go empty lo, empty hi, full lo, full hi, wrap.
// - When empty, reads are blocked and last read word is held.
`timescale 1ns/1ps
`include "dcfp_defs.svh"

module dcfp_fifo #(
  parameter int ADDR_W = `DCFP_ADDR_W
) (
  // Write side clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Read side clock
  input wire logic RD_CLK,
  // Write port
  input wire logic [8:0] WRITE_DATA_IN,
  input wire logic PRIMARY_WRITE_ENABLE_N,
  input wire logic SECONDARY_ENABLE_OR_LOAD,
  // Read port
  input wire logic READ_ENABLE_A_N,
  input wire logic READ_ENABLE_B_N,
  input wire logic OUTPUT_DRIVE_ENABLE_N,
  output logic [8:0] READ_DATA_OUT,
  output logic READ_DATA_OE,
  // Status flags, all active low
  output logic EMPTY_INDICATOR_N,
  output logic ALMOST_EMPTY_INDICATOR_N,
  output logic FULL_INDICATOR_N,
  output logic ALMOST_FULL_INDICATOR_N
);

  localparam int PTR_W = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
  localparam dcfp_pkg::dcfp_ofs_t OFS_RST = '{
    f_hi: `DCFP_OFS_HI_RST, f_lo: `DCFP_OFS_LO_RST,
    e_hi: `DCFP_OFS_HI_RST, e_lo: `DCFP_OFS_LO_RST};

  function automatic logic [PTR_W-1:0] g2b(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // Storage, written on the write clock only
  // ---------------------------------------------------------------
  logic [8:0] mem [DEPTH];

  // ---------------------------------------------------------------
  // Write domain
  // ---------------------------------------------------------------
  dcfp_pkg::dcfp_mode_t mode_r;
  dcfp_pkg::dcfp_sel_t wsel_r, wsel_nxt;
  dcfp_pkg::dcfp_ofs_t ofs_r, snap_r;
  logic [PTR_W-1:0] wbin_r, wgray_r, rg_s1, rg_s2;
  logic full_n_r, af_n_r, req_r, ack_s1, ack_s2, dirty_r;
  logic wr_req, wr_fire, ofs_wr, hs_busy;
  logic [PTR_W-1:0] wbin_nxt, rbin_w, wlevel, wlevel_nxt, full_ofs;
  logic [17:0] f_cat;
  // Read-side pointer and return toggle, sampled here through two flops
  logic [PTR_W-1:0] rgray_r;
  logic ack_r;

  // Write qualifiers; a load-mode low secondary steers to offsets
  assign wr_req = !PRIMARY_WRITE_ENABLE_N && SECONDARY_ENABLE_OR_LOAD;
  assign wr_fire = wr_req && full_n_r;
  assign ofs_wr = (mode_r == dcfp_pkg::DCFP_MODE_LOAD) &&
                  !PRIMARY_WRITE_ENABLE_N &&
                  !SECONDARY_ENABLE_OR_LOAD;
  assign wbin_nxt = wbin_r + PTR_W'(wr_fire);
  assign rbin_w = g2b(rg_s2);
  assign wlevel = wbin_r - rbin_w;
  assign wlevel_nxt = wbin_nxt - rbin_w;
  assign f_cat = {ofs_r.f_hi, ofs_r.f_lo};
  assign full_ofs = PTR_W'(f_cat[ADDR_W-1:0]);
  assign hs_busy = req_r != ack_s2;

  // Offset selector steps on each offset write and wraps
  always_comb begin
    case (wsel_r)
      dcfp_pkg::DCFP_SEL_E_LO: wsel_nxt = dcfp_pkg::DCFP_SEL_E_HI;
      dcfp_pkg::DCFP_SEL_E_HI: wsel_nxt = dcfp_pkg::DCFP_SEL_F_LO;
      dcfp_pkg::DCFP_SEL_F_LO: wsel_nxt = dcfp_pkg::DCFP_SEL_F_HI;
      default: wsel_nxt = dcfp_pkg::DCFP_SEL_E_LO;
    endcase
  end

  // Buffer write; no reset so the array stays plain flops
  always_ff @(posedge CORE_CLK) begin
    if (!SYS_RST && wr_fire) begin
      mem[wbin_r[ADDR_W-1:0]] <= WRITE_DATA_IN;
    end
  end

  // Mode strap is caught while reset is held
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_r <= dcfp_pkg::dcfp_mode_t'(SECONDARY_ENABLE_OR_LOAD);
    end
  end

  // Write pointer, full flags and read pointer synchroniser
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wbin_r <= '0;
      wgray_r <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
      full_n_r <= 1'b1;
      af_n_r <= 1'b1;
    end else begin
      wbin_r <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      rg_s1 <= rgray_r;
      rg_s2 <= rg_s1;
      full_n_r <= wlevel_nxt != DEPTH_P;
      af_n_r <= wlevel_nxt < (DEPTH_P - full_ofs);
    end
  end

  // Offset registers; an offset write is never lost to the handshake
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ofs_r <= OFS_RST;
      wsel_r <= dcfp_pkg::DCFP_SEL_E_LO;
    end else if (ofs_wr) begin
      wsel_r <= wsel_nxt;
      case (wsel_r)
        dcfp_pkg::DCFP_SEL_E_LO: ofs_r.e_lo <= WRITE_DATA_IN;
        dcfp_pkg::DCFP_SEL_E_HI: ofs_r.e_hi <= WRITE_DATA_IN;
        dcfp_pkg::DCFP_SEL_F_LO: ofs_r.f_lo <= WRITE_DATA_IN;
        default: ofs_r.f_hi <= WRITE_DATA_IN;
      endcase
    end
  end

  // Snapshot handshake toward the read side; snap holds while busy
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      snap_r <= OFS_RST;
      req_r <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      dirty_r <= 1'b0;
    end else begin
      ack_s1 <= ack_r;
      ack_s2 <= ack_s1;
      if (dirty_r && !hs_busy) begin
        snap_r <= ofs_r;
        req_r <= !req_r;
      end
      // A new offset write wins over the clear of the pending mark
      dirty_r <= ofs_wr || (dirty_r && hs_busy);
    end
  end

  assign FULL_INDICATOR_N = full_n_r;
  assign ALMOST_FULL_INDICATOR_N = af_n_r;

  // ---------------------------------------------------------------
  // Read domain
  // ---------------------------------------------------------------
  dcfp_pkg::dcfp_sel_t rsel_r, rsel_nxt;
  dcfp_pkg::dcfp_ofs_t rofs_r;
  logic rrst_s1, rrst_r, mode_s1, mode_s2, ld_s1, ld_s2;
  logic req_s1, req_s2;
  logic [PTR_W-1:0] rbin_r, wg_s1, wg_s2;
  logic [8:0] rdata_r, ofs_word;
  logic empty_n_r, ae_n_r, oe_r;
  logic rd_req, ofs_rd_mode, rd_fire, ofs_rd;
  logic [PTR_W-1:0] rbin_nxt, wbin_rd, rlevel, rlevel_nxt, empty_ofs;
  logic [17:0] e_cat;

  // Read decode; offset readback takes over while load is low
  assign rd_req = !READ_ENABLE_A_N && !READ_ENABLE_B_N;
  assign ofs_rd_mode = !mode_s2 && !ld_s2;
  assign ofs_rd = rd_req && ofs_rd_mode;
  assign rd_fire = rd_req && !ofs_rd_mode && empty_n_r;
  assign rbin_nxt = rbin_r + PTR_W'(rd_fire);
  assign wbin_rd = g2b(wg_s2);
  assign rlevel = wbin_rd - rbin_r;
  assign rlevel_nxt = wbin_rd - rbin_nxt;
  assign e_cat = {rofs_r.e_hi, rofs_r.e_lo};
  assign empty_ofs = PTR_W'(e_cat[ADDR_W-1:0]);

  // Readback selector follows the same wrap order as writes
  always_comb begin
    case (rsel_r)
      dcfp_pkg::DCFP_SEL_E_LO: rsel_nxt = dcfp_pkg::DCFP_SEL_E_HI;
      dcfp_pkg::DCFP_SEL_E_HI: rsel_nxt = dcfp_pkg::DCFP_SEL_F_LO;
      dcfp_pkg::DCFP_SEL_F_LO: rsel_nxt = dcfp_pkg::DCFP_SEL_F_HI;
      default: rsel_nxt = dcfp_pkg::DCFP_SEL_E_LO;
    endcase
  end

  assign ofs_word = (rsel_r == dcfp_pkg::DCFP_SEL_E_LO) ? rofs_r.e_lo :
                    (rsel_r == dcfp_pkg::DCFP_SEL_E_HI) ? rofs_r.e_hi :
                    (rsel_r == dcfp_pkg::DCFP_SEL_F_LO) ? rofs_r.f_lo :
                    rofs_r.f_hi;

  // Reset and static levels cross into the read clock by two flops
  always_ff @(posedge RD_CLK) begin
    rrst_s1 <= SYS_RST;
    rrst_r <= rrst_s1;
    mode_s1 <= mode_r;
    mode_s2 <= mode_s1;
    ld_s1 <= SECONDARY_ENABLE_OR_LOAD;
    ld_s2 <= ld_s1;
  end

  // Read pointer, empty flags and data register
  always_ff @(posedge RD_CLK) begin
    if (rrst_r) begin
      rbin_r <= '0;
      rgray_r <= '0;
      wg_s1 <= '0;
      wg_s2 <= '0;
      empty_n_r <= 1'b0;
      ae_n_r <= 1'b0;
      rdata_r <= `DCFP_DATA_RST;
      rsel_r <= dcfp_pkg::DCFP_SEL_E_LO;
    end else begin
      rbin_r <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      wg_s1 <= wgray_r;
      wg_s2 <= wg_s1;
      empty_n_r <= rlevel_nxt != '0;
      ae_n_r <= rlevel_nxt > empty_ofs;
      if (rd_fire) begin
        rdata_r <= mem[rbin_r[ADDR_W-1:0]];
      end else if (ofs_rd) begin
        rdata_r <= ofs_word;
        rsel_r <= rsel_nxt;
      end
    end
  end

  // Offset copy lands only on a request toggle, so it is always whole
  always_ff @(posedge RD_CLK) begin
    if (rrst_r) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      ack_r <= 1'b0;
      rofs_r <= OFS_RST;
    end else begin
      req_s1 <= req_r;
      req_s2 <= req_s1;
      if (req_s2 != ack_r) begin
        rofs_r <= snap_r;
        ack_r <= req_s2;
      end
    end
  end

  // Drive enable registered; the pad logic floats the bus from it
  always_ff @(posedge RD_CLK) begin
    if (rrst_r) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= !OUTPUT_DRIVE_ENABLE_N;
    end
  end

  assign READ_DATA_OUT = rdata_r;
  assign READ_DATA_OE = oe_r;
  assign EMPTY_INDICATOR_N = empty_n_r;
  assign ALMOST_EMPTY_INDICATOR_N = ae_n_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  dual_write_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (mode_r == dcfp_pkg::DCFP_MODE_DUAL && !PRIMARY_WRITE_ENABLE_N &&
     SECONDARY_ENABLE_OR_LOAD && full_n_r) |=>
    wbin_r == $past(wbin_r) + PTR_W'(1))
    else $error("dual mode write did not advance");

  load_mode_write_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (mode_r == dcfp_pkg::DCFP_MODE_LOAD && PRIMARY_WRITE_ENABLE_N) |=>
    wbin_r == $past(wbin_r))
    else $error("write without primary enable");

  full_block_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !full_n_r |=> wbin_r == $past(wbin_r))
    else $error("write taken while full");

  level_bound_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wlevel <= DEPTH_P)
    else $error("fill level above depth");

  offset_walk_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (ofs_wr && wsel_r == dcfp_pkg::DCFP_SEL_F_HI) |=>
    wsel_r == dcfp_pkg::DCFP_SEL_E_LO && ofs_r.f_hi == $past(WRITE_DATA_IN))
    else $error("offset sequence broken");

  reset_state_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    $past(SYS_RST) |-> (wbin_r == '0 && ofs_r == OFS_RST && full_n_r))
    else $error("reset state wrong");

  read_advance_a: assert property (
    @(posedge RD_CLK) disable iff (rrst_r)
    (rd_req && !ofs_rd_mode && empty_n_r) |=>
    rbin_r == $past(rbin_r) + PTR_W'(1))
    else $error("read did not advance");

  empty_hold_a: assert property (
    @(posedge RD_CLK) disable iff (rrst_r)
    (!empty_n_r && !ofs_rd) |=>
    (rdata_r == $past(rdata_r) && rbin_r == $past(rbin_r)))
    else $error("read taken while empty");

  drive_enable_a: assert property (
    @(posedge RD_CLK) disable iff (rrst_r)
    // Sampled reset term skips the edge that still loads the reset value
    (!rrst_r && !OUTPUT_DRIVE_ENABLE_N) ##1 !OUTPUT_DRIVE_ENABLE_N |->
    READ_DATA_OE)
    else $error("output not driven");

endmodule // dcfp_fifo

// ### verification/dcfp_reader_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Reading party at the output port
// ---------------------------------------------------------------
module dcfp_reader_model (
  // Read clock and bench requests
  input wire logic rd_clk,
  input wire logic [15:0] n_req,
  input wire logic half_en,
  input wire logic ofs_rd,
  // Device side
  input wire logic empty_n,
  input wire logic [8:0] q_bus,
  output logic ren_a_n = 1'b1,
  output logic ren_b_n = 1'b1
);
  logic [8:0] got[$];
  int issued = 0;
  logic pend = 1'b0;
  logic want;
  // Enables move at the falling edge so the rising edge sees them settled
  always @(negedge rd_clk) begin
    if (pend) got.push_back(q_bus);
    want = issued < n_req;
    // A word only counts when the device can hand one over
    pend = want && (empty_n || ofs_rd);
    if (pend) issued++;
    ren_a_n <= !(want || half_en);
    ren_b_n <= !want;
  end
endmodule // dcfp_reader_model

// ### verification/test_dual_clock_fifo_prog_flags.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the dual clock buffer
// ---------------------------------------------------------------
module test_dual_clock_fifo_prog_flags;
  localparam int AW = 4;
  localparam int DEPTH = 1 << AW;
  logic clk = 0, rd_clk = 0, rst = 1;
  logic [8:0] wdata = 9'h000;
  logic wen_n = 1, sec = 1, oe_n = 0, half_en = 0, ofs_rd = 0;
  logic [15:0] n_req = 16'h0000;
  logic [8:0] q, q_bus, last;
  logic q_oe, ef_n, ae_n, ff_n, af_n, ren_a_n, ren_b_n;
  int n_mismatch = 0, checked = 0;
  logic [8:0] sent[$];

  // Clocks never share an edge, so no race between the two sides
  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever #40 rd_clk = ~rd_clk;
  end
  // Floating bus when the device does not drive it
  assign q_bus = q_oe ? q : 'z;

  dcfp_fifo #(.ADDR_W(AW)) dut (.CORE_CLK(clk), .SYS_RST(rst),
    .RD_CLK(rd_clk), .WRITE_DATA_IN(wdata), .PRIMARY_WRITE_ENABLE_N(wen_n),
    .SECONDARY_ENABLE_OR_LOAD(sec), .READ_ENABLE_A_N(ren_a_n),
    .READ_ENABLE_B_N(ren_b_n), .OUTPUT_DRIVE_ENABLE_N(oe_n),
    .READ_DATA_OUT(q), .READ_DATA_OE(q_oe), .EMPTY_INDICATOR_N(ef_n),
    .ALMOST_EMPTY_INDICATOR_N(ae_n), .FULL_INDICATOR_N(ff_n),
    .ALMOST_FULL_INDICATOR_N(af_n));
  dcfp_reader_model rdr (.rd_clk(rd_clk), .n_req(n_req),
    .half_en(half_en), .ofs_rd(ofs_rd), .empty_n(ef_n), .q_bus(q_bus),
    .ren_a_n(ren_a_n), .ren_b_n(ren_b_n));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // No traffic while reset is held; mode follows sec meanwhile
  task do_reset(input logic mode);
    @(negedge clk);
    rst = 1;
    sec = mode;
    wen_n = 1;
    repeat (8) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge rd_clk);
  endtask

  // Write n words back to back from empty, flags checked per level
  task fill(input int n, input int af_at, input logic [8:0] seed);
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      chk("almost full", {8'h00, af_n}, {8'h00, i < af_at});
      chk("full", {8'h00, ff_n}, {8'h00, i < DEPTH});
      wen_n = (i == n);
      wdata = seed ^ 9'(i * 37);
      if (i < n && i < DEPTH) sent.push_back(wdata);
    end
  endtask

  // Read n words through the reader and compare in order
  task drain(input int n);
    int base;
    base = rdr.got.size();
    n_req = 16'(rdr.issued + n);
    for (int k = 0; k < 200 && rdr.got.size() < base + n; k++)
      @(negedge rd_clk);
    repeat (3) @(negedge rd_clk);
    chk("read count", 9'(rdr.got.size() - base), 9'(n));
    for (int k = 0; k < n; k++)
      chk("read word", rdr.got[base + k], sent.pop_front());
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_dual;
    @(negedge clk);
    sec = 0;
    wen_n = 0;
    repeat (3) @(negedge clk);
    wen_n = 1;
    sec = 1;
    fill(18, DEPTH - 7, 9'h1FF);
    last = sent[$];
    repeat (8) @(negedge rd_clk);
    chk("not empty", {8'h00, ef_n}, 9'h001);
    chk("not almost empty", {8'h00, ae_n}, 9'h001);
    drain(16);
    chk("empty", {8'h00, ef_n}, 9'h000);
    chk("almost empty", {8'h00, ae_n}, 9'h000);
    n_req = n_req + 16'h0002;
    repeat (5) @(negedge rd_clk);
    chk("held word", q, last);
    n_req = 16'(rdr.issued);
    $display("done: dual enable fill and drain");
  endtask

  task t_half;
    fill(1, DEPTH - 7, 9'h0A5);
    repeat (8) @(negedge rd_clk);
    half_en = 1;
    repeat (6) @(negedge rd_clk);
    chk("half enable no read", {8'h00, ef_n}, 9'h001);
    half_en = 0;
    drain(1);
    oe_n = 1;
    repeat (3) @(negedge rd_clk);
    chk("drive off", {8'h00, q_oe}, 9'h000);
    oe_n = 0;
    repeat (3) @(negedge rd_clk);
    chk("drive on", {8'h00, q_oe}, 9'h001);
    $display("done: single enable and output drive");
  endtask

  task t_load;
    int base;
    do_reset(0);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      sec = 0;
      wen_n = 0;
      wdata = (k == 0) ? 9'h002 : (k == 2) ? 9'h003 : 9'h000;
    end
    @(negedge clk);
    wen_n = 1;
    // A burst of offset writes needs two handshake rounds to land
    repeat (12) @(negedge rd_clk);
    ofs_rd = 1;
    base = rdr.got.size();
    n_req = 16'(rdr.issued + 4);
    repeat (8) @(negedge rd_clk);
    for (int k = 0; k < 4; k++)
      chk("offset readback", rdr.got[base + k],
        (k == 0) ? 9'h002 : (k == 2) ? 9'h003 : 9'h000);
    ofs_rd = 0;
    sec = 1;
    repeat (6) @(negedge rd_clk);
    fill(14, DEPTH - 3, 9'h100);
    drain(11);
    chk("above empty offset", {8'h00, ae_n}, 9'h001);
    drain(1);
    chk("at empty offset", {8'h00, ae_n}, 9'h000);
    drain(2);
    $display("done: offset load mode");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    do_reset(1);
    chk("reset empty", {8'h00, ef_n}, 9'h000);
    chk("reset almost empty", {8'h00, ae_n}, 9'h000);
    chk("reset full", {8'h00, ff_n}, 9'h001);
    chk("reset almost full", {8'h00, af_n}, 9'h001);
    chk("reset data", q, 9'h000);
    $display("done: reset state");
    t_dual;
    t_half;
    t_load;
    report_and_stop;
  end

  // Whole run needs well under a tenth of this span
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
endmodule // test_dual_clock_fifo_prog_flags
